// file: include/ocp_pkg.sv
/*
  Package for the optional configuration pin controller: register map,
  field positions, reset values, timing constants, carrier structs.
  Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package ocp_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [3:0] OCP_ADDR_OPTIONS = 4'h0;
  localparam logic [3:0] OCP_ADDR_CONTROL = 4'h4;
  localparam logic [3:0] OCP_ADDR_STATUS = 4'h8;
  localparam logic [3:0] OCP_ADDR_FRAMES = 4'hC;

  // OPTIONS fields
  localparam int OCP_OPT_AS_TRISTATE = 0;
  localparam int OCP_OPT_USER_CLK = 1;
  localparam int OCP_OPT_INIT_DONE = 2;
  localparam int OCP_OPT_CHIP_WIDE_OUTPUT_ENABLE = 3;
  localparam int OCP_OPT_DEV_CLR = 4;
  localparam int OCP_OPT_W = 5;
  localparam logic [OCP_OPT_W-1:0] OCP_OPT_RESET = 5'h00;

  // CONTROL fields (write 1 pulses)
  localparam int OCP_CTL_FRAME = 0;
  localparam int OCP_CTL_LAST = 1;

  // STATUS fields
  localparam int OCP_ST_STATE_LO = 0;
  localparam int OCP_ST_USER_MODE = 4;
  localparam int OCP_ST_OPT_LOADED = 5;
  localparam int OCP_ST_INIT_LOW = 6;
  localparam int OCP_ST_RESTART = 7;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int OCP_CLK_HZ = 40_000_000;
  localparam int OCP_INIT_CYCLES = 16;
  // Internal init oscillator period, ns, and its divider count
  localparam int OCP_INT_OSC_NS = 100;
  localparam int OCP_INT_DIV = (OCP_INT_OSC_NS * (OCP_CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int OCP_DIV_W = 4;
  localparam int OCP_CNT_W = 8;

  typedef enum logic [2:0] {
    OCP_IDLE,
    OCP_CONFIG,
    OCP_INIT,
    OCP_USER
  } ocp_state_t;

  // Active serial pin group
  typedef struct packed {
    logic dclk;
    logic config_serial_data_in;
    logic csn;
    logic cmd;
  } ocp_as_t;

  // Optional pin group: user start-up clock, init-complete,
  // chip-wide output enable, chip-wide clear
  typedef struct packed {
    logic user_clk;
    logic init_done;
    logic chip_wide_output_enable;
    logic dev_clr_n;
  } ocp_opt_pins_t;

endpackage

// file: hw/ocp_ctrl.sv
/*
  Optional configuration pin controller: sequences configuration,
  initialization and user mode; steers the active serial pins, the
  optional pins and the chip-wide output enable and clear.
  Assumes pin inputs are asynchronous and are synchronised here; the
  pad ring resolves pin levels from the output enables and pull-ups.
*/
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - With tri-state option, AS clock, data, select and command float in user mode.
// - An optional pin whose option is off works as plain user I/O.
// - During configuration, disabled optional pins float with weak pull-ups.
// - With start-up clock option, initialization steps on the user start-up clock.
// - Init-complete output floats while restart is low and at configuration start.
// - Once the init-complete option loads in the first frame, drive it low.
// - When initialization ends, release init-complete and enter user mode.
// - Enabled output-enable pin low floats all I/O; high lets I/O behave.
// - Enabled clear pin low clears all registers; high lets them operate.
module ocp_ctrl
  import ocp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Configuration pins
  input wire logic config_restart_n_in,
  input wire ocp_opt_pins_t opt_pins_in,
  output ocp_opt_pins_t opt_pins_out,
  output ocp_opt_pins_t opt_pins_oe_out,
  output ocp_opt_pins_t opt_pullup_out,
  input wire ocp_as_t as_pins_in,
  output ocp_as_t as_pins_out,
  output ocp_as_t as_pins_oe_out,
  // User I/O and fabric
  input wire ocp_opt_pins_t user_io_out_in,
  input wire ocp_opt_pins_t user_io_oe_in,
  output ocp_opt_pins_t user_io_in_out,
  input wire ocp_as_t as_user_out_in,
  input wire ocp_as_t as_user_oe_in,
  output logic user_mode_out,
  output logic io_tristate_all_out,
  output logic fabric_clear_out
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [5:0] sync1;
  logic [5:0] sync2;
  wire [5:0] raw_pins = {config_restart_n_in, as_pins_in.config_serial_data_in,
    opt_pins_in.user_clk, opt_pins_in.init_done, opt_pins_in.chip_wide_output_enable,
    opt_pins_in.dev_clr_n};

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
    end else begin
      sync1 <= raw_pins;
      sync2 <= sync1;
    end
  end

  wire restart_n_s = sync2[5];
  wire user_clk_s = sync2[3];
  wire chip_wide_output_enable_s = sync2[1];
  wire dev_clr_n_s = sync2[0];

  // ****************************************************
  // Registers and bus decode
  // ****************************************************
  logic [OCP_OPT_W-1:0] options;
  logic [OCP_OPT_W-1:0] loaded_opts;
  logic opt_loaded;
  logic [OCP_CNT_W-1:0] frames;
  ocp_state_t state;
  logic [OCP_CNT_W-1:0] init_cnt;
  logic init_low;
  logic user_clk_d;
  logic [OCP_DIV_W-1:0] div_cnt;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  wire wr_opt = avs_write_in && avs_byteenable_in[0]
    && avs_address_in == OCP_ADDR_OPTIONS;
  wire wr_ctl = avs_write_in && avs_byteenable_in[0]
    && avs_address_in == OCP_ADDR_CONTROL;
  wire frame_pulse = wr_ctl && avs_writedata_in[OCP_CTL_FRAME];
  wire last_pulse = wr_ctl && avs_writedata_in[OCP_CTL_LAST];
  // One-cycle answer: waitrequest high only in the first request cycle
  logic ack;
  wire req = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = req && !ack;
  wire take = req && ack;

  wire opt_user_clk = loaded_opts[OCP_OPT_USER_CLK];
  wire opt_init_done = loaded_opts[OCP_OPT_INIT_DONE];
  wire opt_chip_wide_output_enable = loaded_opts[OCP_OPT_CHIP_WIDE_OUTPUT_ENABLE];
  wire opt_dev_clr = loaded_opts[OCP_OPT_DEV_CLR];
  wire opt_as_tri = loaded_opts[OCP_OPT_AS_TRISTATE];

  // ****************************************************
  // Initialization tick
  // ****************************************************
  wire div_tick = div_cnt == OCP_DIV_W'(OCP_INT_DIV - 1);
  wire user_clk_rise = user_clk_s && !user_clk_d;
  wire init_tick = opt_user_clk ? user_clk_rise : div_tick;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= '0;
      // Same level as the synchroniser's reset, so no false edge follows
      user_clk_d <= 1'b1;
    end else begin
      div_cnt <= div_tick ? '0 : div_cnt + 1'b1;
      user_clk_d <= user_clk_s;
    end
  end

  // ****************************************************
  // Configuration sequencer
  // ****************************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= OCP_IDLE;
      loaded_opts <= OCP_OPT_RESET;
      opt_loaded <= 1'b0;
      frames <= '0;
      init_cnt <= '0;
      init_low <= 1'b0;
    end else if (!restart_n_s) begin
      state <= OCP_IDLE;
      loaded_opts <= OCP_OPT_RESET;
      opt_loaded <= 1'b0;
      frames <= '0;
      init_cnt <= '0;
      init_low <= 1'b0;
    end else begin
      case (state)
        OCP_IDLE: begin
          state <= OCP_CONFIG;
        end
        OCP_CONFIG: begin
          if (take && frame_pulse) begin
            frames <= frames + 1'b1;
            if (!opt_loaded) begin
              loaded_opts <= options;
              opt_loaded <= 1'b1;
              init_low <= options[OCP_OPT_INIT_DONE];
            end
          end
          if (take && last_pulse && opt_loaded) begin
            state <= OCP_INIT;
            init_cnt <= '0;
          end
        end
        OCP_INIT: begin
          if (init_tick) begin
            init_cnt <= init_cnt + 1'b1;
            if (init_cnt == OCP_CNT_W'(OCP_INIT_CYCLES - 1)) begin
              state <= OCP_USER;
              init_low <= 1'b0;
            end
          end
        end
        OCP_USER: begin
          state <= OCP_USER;
        end
        default: begin
          state <= OCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      options <= OCP_OPT_RESET;
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= req && !ack;
      if (take && wr_opt) begin
        options <= avs_writedata_in[OCP_OPT_W-1:0];
      end
      if (req && !ack && avs_read_in) begin
        rdata <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    case (avs_address_in)
      OCP_ADDR_OPTIONS: next_rdata[OCP_OPT_W-1:0] = options;
      OCP_ADDR_STATUS: begin
        next_rdata[OCP_ST_STATE_LO +: 3] = state;
        next_rdata[OCP_ST_USER_MODE] = state == OCP_USER;
        next_rdata[OCP_ST_OPT_LOADED] = opt_loaded;
        next_rdata[OCP_ST_INIT_LOW] = init_low;
        next_rdata[OCP_ST_RESTART] = restart_n_s;
      end
      OCP_ADDR_FRAMES: next_rdata[OCP_CNT_W-1:0] = frames;
      default: next_rdata = '0;
    endcase
  end
  assign avs_readdata_out = rdata;

  // ****************************************************
  // Pin steering
  // ****************************************************
  wire in_user = state == OCP_USER;
  assign user_mode_out = in_user;
  // override only after configuration, when the option is on
  wire force_tri = in_user && opt_chip_wide_output_enable && !chip_wide_output_enable_s;
  assign io_tristate_all_out = force_tri;
  assign fabric_clear_out = in_user && opt_dev_clr && !dev_clr_n_s;

  // Which optional pins act as user I/O: all before options load
  ocp_opt_pins_t as_io;
  assign as_io = {!opt_user_clk, !opt_init_done, !opt_chip_wide_output_enable,
    !opt_dev_clr};

  // User I/O drives only in user mode; floats with pull-up otherwise
  assign opt_pins_out = user_io_out_in & as_io;
  ocp_opt_pins_t io_oe;
  assign io_oe = (in_user && !force_tri) ? (user_io_oe_in & as_io) : '0;
  // Open drain: low only while init_low, released at the end
  assign opt_pins_oe_out = io_oe | {1'b0, opt_init_done && init_low,
    2'b00};
  assign opt_pullup_out = in_user ? '0 : as_io;
  assign user_io_in_out = {user_clk_s, sync2[2], chip_wide_output_enable_s, dev_clr_n_s} &
    as_io;

  // AS pins: config_serial_data_in is input only; in user mode they float if chosen
  wire as_float = in_user && (opt_as_tri || force_tri);
  assign as_pins_out = as_user_out_in;
  assign as_pins_oe_out = (in_user && !as_float) ?
    (as_user_oe_in & 4'hB) : '0;

  // ****************************************************
  // Checks
  // ****************************************************
  init_float_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !restart_n_s |=> !opt_pins_oe_out.init_done)
    else $error("init-complete driven during restart");
  cfg_start_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (!in_user && !opt_loaded) |-> !opt_pins_oe_out.init_done)
    else $error("init-complete driven before options load");
  init_low_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (state == OCP_CONFIG && restart_n_s && take && frame_pulse
     && !opt_loaded && options[OCP_OPT_INIT_DONE])
    |=> opt_pins_oe_out.init_done && !opt_pins_out.init_done)
    else $error("init-complete not pulled low after first frame");
  init_release_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    ($rose(in_user) && opt_init_done) |-> !opt_pins_oe_out.init_done)
    else $error("init-complete not released at user mode");
  user_entry_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (state == OCP_INIT && restart_n_s && init_tick
     && init_cnt == OCP_CNT_W'(OCP_INIT_CYCLES - 1))
    |=> (in_user && !init_low))
    else $error("user mode not entered at end of init");
  as_tristate_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (in_user && opt_as_tri) |-> as_pins_oe_out == '0)
    else $error("active serial pins driven in user mode");
  cfg_float_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    !in_user |-> ((opt_pins_oe_out & as_io) == '0
      && (opt_pullup_out & as_io) == as_io))
    else $error("optional pin not floating with pull-up");
  oe_override_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (in_user && opt_chip_wide_output_enable && !chip_wide_output_enable_s)
    |-> (io_oe == '0 && as_pins_oe_out == '0))
    else $error("output-enable override ignored");
  clear_all_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (in_user && opt_dev_clr) |-> fabric_clear_out == !dev_clr_n_s)
    else $error("chip-wide clear mismatch");
  int_clock_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (state == OCP_INIT && !opt_user_clk && restart_n_s)
    |-> ##[0:4] init_tick)
    else $error("internal init clock stalled");
  user_io_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (in_user && !opt_chip_wide_output_enable && !force_tri)
    |-> opt_pins_oe_out.chip_wide_output_enable == user_io_oe_in.chip_wide_output_enable)
    else $error("unused option pin not user I/O");
  user_clk_a: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    (state == OCP_INIT && opt_user_clk && restart_n_s && !user_clk_rise)
    |=> $stable(init_cnt))
    else $error("init advanced without a start-up clock edge");

endmodule

`default_nettype wire

// file: sim/ocp_board_model.sv
/*
  Board model for the optional pin controller: pad levels, the external
  pull-up on init-complete, the start-up clock source and a user-mode
  monitor. Assumes the device drive and enables settle after each edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ocp_board_model
  import ocp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire ocp_opt_pins_t opt_out_in,
  input wire ocp_opt_pins_t opt_oe_in,
  input wire ocp_as_t as_out_in,
  input wire ocp_as_t as_oe_in,
  input wire logic oe_pin_in,
  input wire logic clr_n_pin_in,
  input wire logic uclk_run_in,
  output ocp_opt_pins_t opt_level_out,
  output ocp_as_t as_level_out,
  output logic user_seen_out
);
  // ****************************************************
  // Pad levels
  // ****************************************************
  localparam logic SCAN_PINS_HELD = 1'b1;
  logic uclk;
  logic [1:0] div;
  logic done_q;
  // Released init-complete is pulled high on the board
  assign opt_level_out = {
    opt_oe_in.user_clk ? opt_out_in.user_clk : uclk,
    opt_oe_in.init_done ? opt_out_in.init_done : 1'b1,
    opt_oe_in.chip_wide_output_enable ? opt_out_in.chip_wide_output_enable : oe_pin_in,
    opt_oe_in.dev_clr_n ? opt_out_in.dev_clr_n : clr_n_pin_in};
  // Serial pins carry always-on pull-ups
  assign as_level_out = (as_oe_in & as_out_in) | ~as_oe_in;
  // ****************************************************
  // Start-up clock, 8 system cycles a period, still when stopped
  // ****************************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= 2'h0;
      uclk <= 1'b0;
    end else if (uclk_run_in) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        uclk <= ~uclk;
      end
    end
  end
  // ****************************************************
  // Monitor: a rising init-complete means user mode
  // ****************************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b1;
      user_seen_out <= 1'b0;
    end else begin
      done_q <= opt_level_out.init_done;
      if (opt_level_out.init_done && !done_q) begin
        user_seen_out <= SCAN_PINS_HELD;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/test_config_optional_pin_control.sv
/*
  Testbench for the optional pin controller: register accesses over
  Avalon-MM, two configuration runs, overrides and restart.
  Assumes the board model resolves every pad level.
*/
`timescale 1ns/1ps
`default_nettype none
module test_config_optional_pin_control;
  import ocp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic config_restart_n_in = 1'b1;
  ocp_opt_pins_t opt_pins_in, opt_pins_out, opt_pins_oe_out, opt_pullup_out;
  ocp_opt_pins_t user_io_in_out;
  ocp_opt_pins_t user_io_out_in = 4'h5;
  ocp_opt_pins_t user_io_oe_in = 4'hF;
  ocp_as_t as_pins_in, as_pins_out, as_pins_oe_out;
  ocp_as_t as_user_out_in = 4'hA;
  ocp_as_t as_user_oe_in = 4'hF;
  logic user_mode_out, io_tristate_all_out, fabric_clear_out, user_seen;
  logic oe_pin = 1'b1;
  logic clr_n_pin = 1'b1;
  logic uclk_run = 1'b0;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] rd;

  ocp_ctrl DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .config_restart_n_in(config_restart_n_in), .opt_pins_in(opt_pins_in),
    .opt_pins_out(opt_pins_out), .opt_pins_oe_out(opt_pins_oe_out),
    .opt_pullup_out(opt_pullup_out), .as_pins_in(as_pins_in),
    .as_pins_out(as_pins_out), .as_pins_oe_out(as_pins_oe_out),
    .user_io_out_in(user_io_out_in), .user_io_oe_in(user_io_oe_in),
    .user_io_in_out(user_io_in_out), .as_user_out_in(as_user_out_in),
    .as_user_oe_in(as_user_oe_in), .user_mode_out(user_mode_out),
    .io_tristate_all_out(io_tristate_all_out),
    .fabric_clear_out(fabric_clear_out));

  ocp_board_model board (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .opt_out_in(opt_pins_out), .opt_oe_in(opt_pins_oe_out),
    .as_out_in(as_pins_out), .as_oe_in(as_pins_oe_out),
    .oe_pin_in(oe_pin), .clr_n_pin_in(clr_n_pin), .uclk_run_in(uclk_run),
    .opt_level_out(opt_pins_in), .as_level_out(as_pins_in),
    .user_seen_out(user_seen));

  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int i;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (i == 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic wait_user(input int lo, input int hi);
    int n;
    n = 0;
    while (user_mode_out !== 1'b1 && n <= hi) begin
      @(posedge sys_clk_in);
      n++;
    end
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic pin_wait(input logic exp_oe, input logic exp_clr);
    repeat (4) @(posedge sys_clk_in);
    check(32'({io_tristate_all_out, fabric_clear_out}),
      32'({exp_oe, exp_clr}));
  endtask
  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    check(32'(opt_pins_oe_out), 32'h0);
    check(32'(opt_pullup_out), 32'hF);
    bus(1'b1, OCP_ADDR_OPTIONS, 32'h1F);
    bus(1'b0, OCP_ADDR_OPTIONS, 32'h0);
    check(rd, 32'h1F);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, OCP_ADDR_CONTROL, 32'h1);
    @(posedge sys_clk_in);
    check(32'({opt_pins_oe_out.init_done, opt_pins_in.init_done}), 32'h2);
    check(32'(user_seen), 32'h0);
    bus(1'b0, OCP_ADDR_FRAMES, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, OCP_ADDR_CONTROL, 32'h2);
    repeat (100) @(posedge sys_clk_in);
    bus(1'b0, OCP_ADDR_STATUS, 32'h0);
    check(rd & 32'h17, 32'h2);
    uclk_run <= 1'b1;
    wait_user(100, 200);
    check(32'(opt_pins_oe_out.init_done), 32'h0);
    repeat (2) @(posedge sys_clk_in);
    uclk_run <= 1'b0;
    check(32'(user_seen), 32'h1);
    check(32'(as_pins_oe_out), 32'h0);
    check(32'(user_io_in_out), 32'h0);
    oe_pin <= 1'b0;
    pin_wait(1'b1, 1'b0);
    oe_pin <= 1'b1;
    pin_wait(1'b0, 1'b0);
    clr_n_pin <= 1'b0;
    pin_wait(1'b0, 1'b1);
    clr_n_pin <= 1'b1;
    pin_wait(1'b0, 1'b0);
    config_restart_n_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    check(32'({opt_pins_oe_out.init_done, user_mode_out}), 32'h0);
    config_restart_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    bus(1'b1, OCP_ADDR_OPTIONS, 32'h0);
    bus(1'b1, OCP_ADDR_CONTROL, 32'h1);
    @(posedge sys_clk_in);
    check(32'(opt_pins_oe_out), 32'h0);
    bus(1'b1, OCP_ADDR_CONTROL, 32'h2);
    uclk_run <= 1'b1;
    wait_user(50, 100);
    uclk_run <= 1'b0;
    check(32'(opt_pins_oe_out), 32'(user_io_oe_in));
    check(32'(opt_pins_out), 32'(user_io_out_in));
    check(32'(as_pins_oe_out), 32'hB);
    check(32'(as_pins_out), 32'(as_user_out_in));
    oe_pin <= 1'b0;
    pin_wait(1'b0, 1'b0);
    check(32'(user_io_in_out.chip_wide_output_enable), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
